// [bench/ide_host_model.sv]
// Host controller model driving the port strobes
module ide_host_model
  import ide_timing_pkg::*;
(
  input wire logic              clk, iordy,
  input wire logic [2:0]        pio_mode,
  input wire logic [DATA_W-1:0] data_out,
  output logic                  cs0_n, cs1_n, rd_n, wr_n, dmack_n,
  output logic [2:0]            addr,
  output logic [DATA_W-1:0]     data_in
);
  timeunit 1ns; timeprecision 100ps;
  // Active and whole cycle minimums per mode, in clocks
  int act_c[7] = '{33, 25, 20, 16, 14, 13, 11};
  int cyc_c[7] = '{120, 77, 48, 36, 24, 20, 16};
  initial {cs0_n, cs1_n, rd_n, wr_n, dmack_n, addr, data_in} = '1;
  // Write when w is high; b marks an 8-bit register
  task pio(input logic w, b, input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk) {cs0_n, addr, data_in} <= {1'b0, a, d};
    n = (b && pio_mode < 3) ? 58 : act_c[pio_mode];
    @(posedge clk) {rd_n, wr_n} <= {w, !w};
    repeat (n) @(posedge clk);
    for (int k = 0; k < 300 && !iordy && pio_mode < 5; k++) @(posedge clk);
    q = data_out;
    {rd_n, wr_n, data_in} <= {2'b11, ~d};
    repeat (cyc_c[pio_mode] - n) @(posedge clk);
    cs0_n <= 1'b1;
  endtask : pio
  // Mode 0 multiword transfer
  task dma(input logic w, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk) {dmack_n, data_in} <= {1'b0, d};
    @(posedge clk) {rd_n, wr_n} <= {w, !w};
    repeat (43) @(posedge clk);
    q = data_out;
    {rd_n, wr_n, data_in} <= {2'b11, ~d};
    repeat (53) @(posedge clk);
    dmack_n <= 1'b1;
  endtask : dma
endmodule : ide_host_model

// [bench/ide_port_props.sv]
// Checker: port timing of the IDE device end
module ide_port_props
  import ide_timing_pkg::*;
(
  input wire logic              clk, rstn, cs0_n, rd_n, wr_n, iordy, iocs16_n, dmarq, data_oe,
  input wire logic              acc_req, acc_dma, acc_ready, dma_last,
  input wire logic [2:0]        pio_mode, addr,
  input wire logic [4:0]        acc_addr,
  input wire logic [DATA_W-1:0] data_out, acc_rdata
);
  timeunit 1ns; timeprecision 100ps;
  localparam int DQ = 8;
  logic [8:0] low_ff;
  logic       last_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Low time and pending final transfer, kept so the bounds can be asserted
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      low_ff  <= '0;
      last_ff <= 1'b0;
    end
    else
    begin
      low_ff  <= iordy ? '0 : low_ff + 9'h1;
      last_ff <= (acc_req & acc_dma & dma_last) | (last_ff & dmarq);
    end
  a_wait_bound: assert property (low_ff <= IORDY_PULSE_CYC) else $error("wait too long");
  a_fast_nowait: assert property (pio_mode > PIO_LAST_IORDY |-> iordy) else $error("wait in fast mode");
  a_ready_nowait: assert property (acc_req && $past(acc_ready) |-> iordy) else $error("needless wait");
  a_low_cause: assert property ($fell(iordy) |-> acc_req) else $error("wait without access");
  a_data_first: assert property ($rose(iordy) && !rd_n |-> data_out == $past(acc_rdata))
    else $error("data late");
  a_wide_mode: assert property (!iocs16_n |-> pio_mode <= PIO_LAST_IOCS16 && !cs0_n) else $error("bad wide");
  a_drive_read: assert property (data_oe |-> !$past(rd_n)) else $error("drive off read");
  a_addr_taken: assert property (acc_req |-> acc_addr[2:0] == $past(addr)) else $error("bad address");
  a_dmarq_drop: assert property (last_ff && rd_n && wr_n |-> ##[1:DQ] !dmarq) else $error("request late");
  cover property ($fell(iordy));
  cover property ($fell(dmarq));
  cover property (!iocs16_n);
endmodule : ide_port_props
bind ide_dev_port ide_port_props ide_port_props_inst (.*);

// [bench/test_ide_dev_port.sv]
// Testbench of the IDE device port
module test_ide_dev_port import ide_timing_pkg::*;;
  timeunit 1ns; timeprecision 100ps;
  logic clk, rstn, dma_mode_en, acc_ready, acc_wide, dma_want, dma_last;
  logic [2:0] pio_mode;
  logic [15:0] acc_rdata, q;
  wire logic cs0_n, cs1_n, rd_n, wr_n, dmack_n, data_oe, iordy, iocs16_n, dmarq, acc_req, acc_wr, acc_dma;
  wire logic [2:0] addr;
  wire logic [4:0] acc_addr;
  wire logic [15:0] data_in, data_out, acc_wdata;
  int num_errors, n_checks;
  ide_dev_port ide_dev_port_inst (.*);
  ide_host_model ide_host_model_inst (.*);
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task chk(input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task t_modes;
    for (int m = 0; m < 7; m++)
    begin
      @(posedge clk) {pio_mode, acc_rdata} <= {3'(m), 16'h5a00 + 16'(m)};
      ide_host_model_inst.pio(1'b0, m[0], 3'h7, 16'h0, q);
      chk(q, 16'h5a00 + 16'(m));
      chk(16'(acc_wr), 16'h0);
      ide_host_model_inst.pio(1'b1, 1'b0, 3'(m), 16'h1234 + 16'(m), q);
      chk(acc_wdata, 16'h1234 + 16'(m));
      chk(16'(acc_wr), 16'h1);
      chk({11'h0, acc_addr}, 16'h8 + 16'(m));
    end
    $display("modes test done");
  endtask : t_modes
  task t_wait;
    @(posedge clk) {pio_mode, acc_ready, acc_wide, acc_rdata} <= {3'h0, 2'b01, 16'hbeef};
    fork
      ide_host_model_inst.pio(1'b0, 1'b0, 3'h0, 16'h0, q);
      begin
        // Longer than the host's fixed active time, so the host must really wait
        repeat (60) @(posedge clk);
        chk(16'(iordy), 16'h0);
        chk(16'(iocs16_n), 16'h0);
        chk(16'(data_oe), 16'h1);
        acc_ready <= 1'b1;
      end
    join
    chk(q, 16'hbeef);
    // Fast mode with a stalled user side must not stretch the cycle
    @(posedge clk) {pio_mode, acc_ready} <= {3'h6, 1'b0};
    ide_host_model_inst.pio(1'b0, 1'b0, 3'h0, 16'h0, q);
    chk(16'(iordy), 16'h1);
    chk(16'(iocs16_n), 16'h1);
    acc_ready <= 1'b1;
    $display("wait test done");
  endtask : t_wait
  task t_dma;
    @(posedge clk) {dma_mode_en, dma_want, dma_last, acc_rdata} <= {3'b111, 16'h0f0f};
    repeat (3) @(posedge clk);
    chk(16'(dmarq), 16'h1);
    dma_want <= 1'b0;
    ide_host_model_inst.dma(1'b0, 16'h0, q);
    chk(q, 16'h0f0f);
    chk(16'(acc_dma), 16'h1);
    repeat (2) @(posedge clk);
    chk(16'(dmarq), 16'h0);
    $display("dma test done");
  endtask : t_dma
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial
  begin
    {rstn, dma_mode_en, acc_ready, acc_wide, dma_want, dma_last, pio_mode, acc_rdata} = '0;
    acc_ready = 1'b1;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_modes();
    t_wait();
    t_dma();
    print_verdict();
  end
  // About 1000 clocks of tests; allow a wide margin
  initial
  begin
    #60us;
    num_errors++;
    print_verdict();
  end
endmodule : test_ide_dev_port

// [hdl/ide_dev_port.sv]
// Device end of the parallel IDE port: PIO and multiword DMA strobe handling

module ide_dev_port
  import ide_timing_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Mode selection
  input  wire logic [2:0]        pio_mode,
  input  wire logic              dma_mode_en,
  // Host bus (active low strobes)
  input  wire logic              cs0_n,
  input  wire logic              cs1_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic              dmack_n,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  output logic                   iordy,
  output logic                   iocs16_n,
  output logic                   dmarq,
  // User side: register/data access
  output logic                   acc_req,
  output logic                   acc_wr,
  output logic                   acc_dma,
  output logic [4:0]             acc_addr,
  output logic [DATA_W-1:0]      acc_wdata,
  input  wire logic              acc_ready,
  input  wire logic [DATA_W-1:0] acc_rdata,
  input  wire logic              acc_wide,
  // User side: DMA request
  input  wire logic              dma_want,
  input  wire logic              dma_last
);

  // ****************************************
  // Cycle state
  // ****************************************
  // One packed record keeps every register of the port in step
  typedef struct packed {
    cyc_state_t        st;
    logic              wr;
    logic              dma;
    logic [CNT_W-1:0]  low_cnt;
    logic [DATA_W-1:0] rdata;
    logic              oe;
    logic              iordy;
    logic              req;
    logic              dmarq;
    logic              dma_end;
    logic [4:0]        addr;
    logic [DATA_W-1:0] wdata;
  } state_t;

  // Registered state and the value it takes at the next edge
  state_t cur_ff;
  state_t nxt_ff;

  // ****************************************
  // Host bus decode
  // ****************************************
  logic strobe;
  logic sel;
  logic wait_ok;

  // Strobes are levels on the clock; one low phase gives one access
  assign strobe  = ~rd_n | ~wr_n;
  // Task register selected by exactly one chip select; DMA by acknowledge
  assign sel     = (~cs0_n ^ ~cs1_n) | ~dmack_n;
  // Flow control only in modes 0-4; modes 5/6 never insert waits
  assign wait_ok = (pio_mode <= PIO_LAST_IORDY);

  // ****************************************
  // Cycle control
  // ****************************************
  always_comb
  begin
    nxt_ff     = cur_ff;
    nxt_ff.req = 1'b0;
    case (cur_ff.st)
      // Waiting for a strobe on a selected register or with DMA acknowledge
      IDLE:
      begin
        nxt_ff.iordy   = 1'b1;
        nxt_ff.low_cnt = '0;
        // Any host strobe width is accepted; edges alone pace us
        if (strobe && sel)
        begin
          nxt_ff.st    = ACTIVE;
          nxt_ff.wr    = ~wr_n;
          nxt_ff.dma   = ~dmack_n;
          nxt_ff.addr  = {~cs1_n, ~cs0_n, addr};
          // Write data taken at the take edge; the host holds it through the strobe
          nxt_ff.wdata = data_in;
          nxt_ff.req   = 1'b1;
          // Bus drive only for reads; writes leave the data lines to the host
          nxt_ff.oe    = ~rd_n;
          // Drop IORDY only if the answer is not already there and mode allows
          if (wait_ok && !acc_ready && !(~dmack_n))
          begin
            nxt_ff.iordy  = 1'b0;
          end
          else if (acc_ready)
          begin
            // Data presented within the strobe's normal setup window
            nxt_ff.rdata = acc_rdata;
            nxt_ff.st    = DONE;
          end
        end
      end
      // Access handed to the user side; count the stall so the wait stays bounded
      ACTIVE:
      begin
        nxt_ff.low_cnt = cur_ff.low_cnt + CNT_W'(1);
        if (acc_ready)
        begin
          // Data latched this edge, IORDY rises the same edge
          nxt_ff.rdata = acc_rdata;
          nxt_ff.iordy = 1'b1;
          nxt_ff.st    = DONE;
        end
        else if (cur_ff.low_cnt >= CNT_W'(IORDY_PULSE_CYC - 2))
        begin
          // Give up waiting so IORDY stays below its longest pulse
          // Limitation: a user side slower than this hands the host stale data
          nxt_ff.iordy = 1'b1;
          nxt_ff.st    = DONE;
        end
      end
      // Hold here until the strobe negates, so a long strobe is not taken twice
      DONE:
      begin
        nxt_ff.iordy = 1'b1;
        if (!strobe)
        begin
          nxt_ff.st = IDLE;
          nxt_ff.oe = 1'b0;
          // Final DMA strobe negated: drop DMARQ next edge
          if (cur_ff.dma && cur_ff.dma_end)
          begin
            nxt_ff.dmarq   = 1'b0;
            nxt_ff.dma_end = 1'b0;
          end
        end
      end
      default:
      begin
        nxt_ff.st = IDLE;
      end
    endcase

    // ****************************************
    // DMA request
    // ****************************************
    // Request raised on dma_want and held until the final word ends; the final burst word is marked
    if (cur_ff.st == IDLE && dma_mode_en && dma_want && !cur_ff.dma_end)
    begin
      nxt_ff.dmarq = 1'b1;
    end
    if (cur_ff.req && cur_ff.dma && dma_last)
    begin
      nxt_ff.dma_end = 1'b1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // IORDY comes out of reset high so the host never sees a stray wait
      cur_ff <= '{st: IDLE, iordy: 1'b1, default: '0};
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign data_out  = cur_ff.rdata;
  // Released as soon as the read strobe rises, so the bus turns round promptly
  assign data_oe   = cur_ff.oe & ~rd_n;
  assign iordy     = cur_ff.iordy;
  // Valid only for modes 0-2; reported high otherwise
  // Combinational so it follows the chip select without a clock of delay
  assign iocs16_n  = ~(acc_wide && (pio_mode <= PIO_LAST_IOCS16) && ~cs0_n);
  assign dmarq     = cur_ff.dmarq;
  // User-side fields other than acc_req stand until the next access is taken; acc_req pulses for one clock
  assign acc_req   = cur_ff.req;
  assign acc_wr    = cur_ff.wr;
  assign acc_dma   = cur_ff.dma;
  assign acc_addr  = cur_ff.addr;
  assign acc_wdata = cur_ff.wdata;

endmodule : ide_dev_port

// [pkg/ide_timing_pkg.sv]
// Package: modes, timing figures and derived cycle counts for the IDE port device end
package ide_timing_pkg;

  // ****************************************
  // Clock
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 5;

  // ****************************************
  // Timing figures (ns) and derived counts
  // ****************************************
  // IORDY sampling point after strobe assertion
  localparam int unsigned IORDY_SETUP_NS  = 35;
  // Longest IORDY negation within one PIO cycle
  localparam int unsigned IORDY_PULSE_NS  = 1250;
  // Longest delay from final DMA strobe edge to DMARQ negation
  localparam int unsigned DMARQ_RD_MAX_NS = 120;
  localparam int unsigned DMARQ_WR_MAX_NS = 40;

  // Longest times round down, least one cycle
  localparam int unsigned IORDY_PULSE_CYC = IORDY_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned IORDY_SETUP_CYC = IORDY_SETUP_NS / CLK_PERIOD_NS;
  localparam int unsigned DMARQ_RD_CYC    = DMARQ_RD_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned DMARQ_WR_CYC    = DMARQ_WR_MAX_NS / CLK_PERIOD_NS;

  // ****************************************
  // Widths and mode limits
  // ****************************************
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned ADDR_W          = 3;
  localparam int unsigned CNT_W           = 9;
  localparam logic [2:0]  PIO_LAST_IORDY  = 3'h4;
  localparam logic [2:0]  PIO_LAST_IOCS16 = 3'h2;

  typedef enum logic [1:0] {
    IDLE,
    ACTIVE,
    DONE
  } cyc_state_t;

endpackage : ide_timing_pkg
